// >>> dsc_defines.svh
// Constants of the serial control port: sizes, fields, reset values and timing
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// ===========================================================================
// Register file shape
`define DSC_NREG        4
`define DSC_AW          2
`define DSC_DW          32
`define DSC_CNT_W       6

// ===========================================================================
// Instruction byte and control register fields
`define DSC_INS_LAST    6'h07
`define DSC_DATA_LAST   6'h1F
`define DSC_RD_BIT      7
`define DSC_CTRL_ADDR   2'h0
`define DSC_LSB_BIT     0
`define DSC_3W_BIT      1
`define DSC_RST_VAL     32'h00000000

// ===========================================================================
// Timing: sync clock is the core clock divided by four
`define DSC_CORE_NS     10
`define DSC_SYNC_HALF   1'h1

`endif

// >>> dsc_pkg.sv
// Types shared by the serial control port
`include "dsc_defines.svh"

package dsc_pkg;

	// Serial controller states, one-hot
	typedef enum logic [3:0]
	{
		ST_IDLE  = 4'h1,
		ST_INSTR = 4'h2,
		ST_WRITE = 4'h4,
		ST_READ  = 4'h8
	} dsc_state_t;

	// One completed serial write on its way into buffer memory
	typedef struct packed
	{
		logic [`DSC_AW-1:0] addr;
		logic [`DSC_DW-1:0] data;
	} dsc_word_t;

endpackage : dsc_pkg

// >>> dsc_serial_port.sv
// Serial control port with buffer memory, active registers and update strobe
//
// Behaviour
// RL1: Rising update strobe copies buffer memory to active registers; writes alone do not.
// RL2: Host times the update strobe to the sync clock output.
// RL3: Hardware reset high returns all registers and the serial port to reset state.
// RL4: Abort high resets the serial controller at once, ending any transfer.
// RL5: After abort release a new transfer starts from the instruction phase.
// RL6: Host holds the abort input low when it is not used.
// RL7: In 3-wire mode read data leaves on the serial output pin.
// RL8: In 2-wire mode the serial output pin is unused.
// RL9: The port answers only while device select is low.
// RL10: Host supplies the shift clock for every bit.
// RL11: In 3-wire mode the data pin is only an input.
// RL12: In 2-wire mode the data pin turns around and carries read data.
// RL13: Device drives a sync clock output for external timing.
// RL14: Host holds hardware reset high for at least five core cycles.
// RL15: Transfers run MSB first or LSB first as configured.
// RL16: Data sampled on rising shift clock edges, read data changed on falling.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.svh"

module dsc_serial_port
(
	// Core clock and reset
	input  wire logic                               mclk_in,
	input  wire logic                               rstn_in,
	// Device pins
	input  wire logic                               hw_reset_in,
	input  wire logic                               serial_port_abort_in,
	input  wire logic                               cs_n_in,
	input  wire logic                               sclk_in,
	input  wire logic                               sdio_in,
	input  wire logic                               io_update_in,
	output logic                                    sdio_out,
	output logic                                    sdio_oe_out,
	output logic                                    serial_out_pin_out,
	output logic                                    sync_clk_out,
	// Active registers towards the core
	output logic [`DSC_NREG-1:0][`DSC_DW-1:0]       active_regs_out
);

	// =======================================================================
	// Helpers
	// Shift one bit in at the end that the bit order asks for
	function automatic logic [`DSC_DW-1:0] dsc_shift(input logic [`DSC_DW-1:0] sr,
		input logic b, input logic lsb);
		dsc_shift = lsb ? {b, sr[`DSC_DW-1:1]} : {sr[`DSC_DW-2:0], b};
	endfunction : dsc_shift

	// Instruction byte sits at the end the shifter filled
	function automatic logic [7:0] dsc_instr(input logic [`DSC_DW-1:0] sr,
		input logic lsb);
		dsc_instr = lsb ? sr[`DSC_DW-1:`DSC_DW-8] : sr[7:0];
	endfunction : dsc_instr

	// =======================================================================
	// Pin synchronisers
	logic [1:0] sync_q [5];
	logic       sclk_d;
	logic       hw_rst;
	logic       abort;
	logic       cs_n;
	logic       sclk;
	logic       sdi;
	logic       upd;
	logic       sys_rst;

	// Two flops per pin; only the second stage is read by logic
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_sync
			logic pin;
			assign pin = (gi == 0) ? hw_reset_in :
				(gi == 1) ? serial_port_abort_in :
				(gi == 2) ? cs_n_in :
				(gi == 3) ? sclk_in : (gi == 4) ? sdio_in : 1'b0;
			always_ff @(posedge mclk_in)
			begin
				if (!rstn_in)
					sync_q[gi] <= (gi == 2) ? 2'h3 : 2'h0;
				else
					sync_q[gi] <= {sync_q[gi][0], pin};
			end
		end
	endgenerate

	// Update strobe has its own pair, kept apart from the serial group
	logic [1:0] upd_q;
	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
			upd_q <= 2'h0;
		else
			upd_q <= {upd_q[0], io_update_in};
	end

	assign hw_rst = sync_q[0][1];
	assign abort  = sync_q[1][1];
	assign cs_n   = sync_q[2][1];
	assign sclk   = sync_q[3][1];
	assign sdi    = sync_q[4][1];
	assign upd    = upd_q[1];
	// RL3: hardware reset
	assign sys_rst = !rstn_in || hw_rst;

	// Shift clock edges found by the core clock
	logic sclk_rise;
	logic sclk_fall;
	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
			sclk_d <= 1'b0;
		else
			sclk_d <= sclk;
	end
	assign sclk_rise = sclk && !sclk_d;
	assign sclk_fall = !sclk && sclk_d;

	// =======================================================================
	// Sync clock divider and update sampling
	logic       div;
	logic       next_div;
	logic       next_sync_clk;
	logic       upd_prev;
	logic       next_upd_prev;
	logic       copy_now;
	logic       sample;

	// Sync clock runs at a quarter of the core clock
	always_comb
	begin
		sample        = (div == `DSC_SYNC_HALF) && !sync_clk_out;
		next_div      = div + 1'b1;
		next_sync_clk = sync_clk_out;
		next_upd_prev = upd_prev;
		// RL13: sync clock out
		if (div == `DSC_SYNC_HALF)
			next_sync_clk = !sync_clk_out;
		// Strobe is looked at only where the sync clock rises
		if (sample)
			next_upd_prev = upd;
		// RL1: rising strobe copies
		copy_now = sample && upd && !upd_prev;
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst)
		begin
			div          <= 1'b0;
			sync_clk_out <= 1'b0;
			upd_prev     <= 1'b0;
		end
		else
		begin
			div          <= next_div;
			sync_clk_out <= next_sync_clk;
			upd_prev     <= next_upd_prev;
		end
	end

	// =======================================================================
	// Two-entry buffer between serial writes and buffer memory
	dsc_pkg::dsc_word_t fifo_mem [2];
	dsc_pkg::dsc_word_t push_word;
	dsc_pkg::dsc_word_t next_fifo_mem [2];
	logic               wr_ptr;
	logic               rd_ptr;
	logic [1:0]         count;
	logic               next_wr_ptr;
	logic               next_rd_ptr;
	logic [1:0]         next_count;
	logic               push_valid;
	logic               push_ready;
	logic               pop_valid;
	logic               pop_ready;

	// Drain stalls in the copy cycle so a late write waits for the next update
	always_comb
	begin
		push_ready    = (count != 2'h2);
		pop_valid     = (count != 2'h0);
		pop_ready     = !copy_now;
		next_fifo_mem = fifo_mem;
		next_wr_ptr   = wr_ptr;
		next_rd_ptr   = rd_ptr;
		next_count    = count;
		if (push_valid && push_ready)
		begin
			next_fifo_mem[wr_ptr] = push_word;
			next_wr_ptr           = !wr_ptr;
		end
		if (pop_valid && pop_ready)
			next_rd_ptr = !rd_ptr;
		next_count = count + {1'b0, push_valid && push_ready}
			- {1'b0, pop_valid && pop_ready};
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst)
		begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
		fifo_mem <= next_fifo_mem;
	end

	// =======================================================================
	// Buffer memory and active registers
	logic [`DSC_NREG-1:0][`DSC_DW-1:0] buf_mem;
	logic [`DSC_NREG-1:0][`DSC_DW-1:0] next_buf_mem;
	logic [`DSC_NREG-1:0][`DSC_DW-1:0] next_active;
	logic                              lsb_first;
	logic                              three_wire;

	// Bit order and wire mode come from the active control register
	assign lsb_first  = active_regs_out[`DSC_CTRL_ADDR][`DSC_LSB_BIT];
	assign three_wire = active_regs_out[`DSC_CTRL_ADDR][`DSC_3W_BIT];

	always_comb
	begin
		next_buf_mem = buf_mem;
		next_active  = active_regs_out;
		if (pop_valid && pop_ready)
			next_buf_mem[fifo_mem[rd_ptr].addr] = fifo_mem[rd_ptr].data;
		// RL1: update copies buffer
		if (copy_now)
			next_active = buf_mem;
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst)
		begin
			buf_mem         <= {`DSC_NREG{`DSC_RST_VAL}};
			active_regs_out <= {`DSC_NREG{`DSC_RST_VAL}};
		end
		else
		begin
			buf_mem         <= next_buf_mem;
			active_regs_out <= next_active;
		end
	end

	// =======================================================================
	// Serial controller
	dsc_pkg::dsc_state_t     state;
	dsc_pkg::dsc_state_t     next_state;
	logic [`DSC_CNT_W-1:0]   cnt;
	logic [`DSC_CNT_W-1:0]   next_cnt;
	logic [`DSC_DW-1:0]      sr;
	logic [`DSC_DW-1:0]      next_sr;
	logic [`DSC_DW-1:0]      rd_sr;
	logic [`DSC_DW-1:0]      next_rd_sr;
	logic [`DSC_AW-1:0]      addr;
	logic [`DSC_AW-1:0]      next_addr;
	logic [7:0]              ins;
	logic                    ser_clear;
	logic                    next_sdio;
	logic                    next_oe;
	logic                    next_so;

	always_comb
	begin
		next_state = state;
		next_cnt   = cnt;
		next_sr    = sr;
		next_rd_sr = rd_sr;
		next_addr  = addr;
		next_sdio  = sdio_out;
		next_oe    = sdio_oe_out;
		next_so    = serial_out_pin_out;
		push_valid = 1'b0;
		// RL16: sample on rising edge
		ins        = dsc_instr(dsc_shift(sr, sdi, lsb_first), lsb_first);
		push_word  = '{addr: addr, data: dsc_shift(sr, sdi, lsb_first)};
		// RL4: abort or deselect ends the transfer at once
		// RL9: only while selected
		ser_clear  = abort || cs_n;
		if (ser_clear)
		begin
			next_state = dsc_pkg::ST_IDLE;
			next_cnt   = '0;
			next_oe    = 1'b0;
		end
		else
		begin
			case (state)
				// RL5: fresh start at instruction phase
				dsc_pkg::ST_IDLE:
				begin
					next_state = dsc_pkg::ST_INSTR;
					next_cnt   = '0;
				end
				dsc_pkg::ST_INSTR:
				begin
					if (sclk_rise)
					begin
						next_sr  = dsc_shift(sr, sdi, lsb_first);
						next_cnt = cnt + 1'b1;
						if (cnt == `DSC_INS_LAST)
						begin
							next_cnt   = '0;
							next_addr  = ins[`DSC_AW-1:0];
							next_rd_sr = active_regs_out[ins[`DSC_AW-1:0]];
							next_state = ins[`DSC_RD_BIT] ? dsc_pkg::ST_READ
								: dsc_pkg::ST_WRITE;
						end
					end
				end
				dsc_pkg::ST_WRITE:
				begin
					if (sclk_rise)
					begin
						// RL15: bit order
						next_sr  = dsc_shift(sr, sdi, lsb_first);
						next_cnt = cnt + 1'b1;
						if (cnt == `DSC_DATA_LAST)
						begin
							push_valid = 1'b1;
							next_cnt   = '0;
							next_state = dsc_pkg::ST_INSTR;
						end
					end
				end
				dsc_pkg::ST_READ:
				begin
					// RL16: drive on falling edge
					if (sclk_fall)
					begin
						next_sdio  = lsb_first ? rd_sr[0] : rd_sr[`DSC_DW-1];
						next_rd_sr = dsc_shift(rd_sr, 1'b0, lsb_first);
						// RL7: 3-wire uses serial out pin
						// RL8: 2-wire leaves it quiet
						next_so    = three_wire && next_sdio;
						// RL11: 3-wire never drives data pin
						// RL12: 2-wire turns data pin around
						next_oe    = !three_wire;
					end
					if (sclk_rise)
					begin
						next_cnt = cnt + 1'b1;
						if (cnt == `DSC_DATA_LAST)
						begin
							next_cnt   = '0;
							next_oe    = 1'b0;
							next_state = dsc_pkg::ST_INSTR;
						end
					end
				end
				default:
				begin
					next_state = dsc_pkg::ST_IDLE;
					next_oe    = 1'b0;
				end
			endcase
		end
	end

	// RL3: reset returns port to idle
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst)
		begin
			state              <= dsc_pkg::ST_IDLE;
			cnt                <= '0;
			sr                 <= '0;
			rd_sr              <= '0;
			addr               <= '0;
			sdio_out           <= 1'b0;
			sdio_oe_out        <= 1'b0;
			serial_out_pin_out <= 1'b0;
		end
		else
		begin
			state              <= next_state;
			cnt                <= next_cnt;
			sr                 <= next_sr;
			rd_sr              <= next_rd_sr;
			addr               <= next_addr;
			sdio_out           <= next_sdio;
			sdio_oe_out        <= next_oe;
			serial_out_pin_out <= next_so;
		end
	end

endmodule : dsc_serial_port
`default_nettype wire

// >>> dsc_serial_port_chk.sv
// Pin assertions of the serial control port
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.svh"
module dsc_serial_port_chk
(
	// Clock, reset and pins
	input wire logic	mclk_in,
	input wire logic	rstn_in,
	input wire logic	hw_reset_in,
	input wire logic	serial_port_abort_in,
	input wire logic	cs_n_in,
	input wire logic	sclk_in,
	input wire logic	sdio_in,
	input wire logic	io_update_in,
	input wire logic	sdio_out,
	input wire logic	sdio_oe_out,
	input wire logic	serial_out_pin_out,
	input wire logic	sync_clk_out,
	input wire logic [`DSC_NREG-1:0][`DSC_DW-1:0]	active_regs_out
);
	// Pin reset counts as reset too, except where it is checked itself
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in || hw_reset_in);
	logic	thr;
	// Wire mode as the port sees it
	assign thr = active_regs_out[0][`DSC_3W_BIT];
	// ========================================
	// Properties
	property p_sync;
		$rose(sync_clk_out) |=> sync_clk_out ##1 !sync_clk_out;
	endproperty
	a_sync: assert property (p_sync) else $error("sync clock period");
	property p_oe3w;
		thr |-> !sdio_oe_out;
	endproperty
	a_oe3w: assert property (p_oe3w) else $error("data pin driven");
	property p_sdo2w;
		!thr |-> !serial_out_pin_out;
	endproperty
	a_sdo2w: assert property (p_sdo2w) else $error("output pin used");
	property p_cs;
		cs_n_in [*6] |-> !sdio_oe_out && $stable(serial_out_pin_out);
	endproperty
	a_cs: assert property (p_cs) else $error("answer while deselected");
	property p_abort;
		serial_port_abort_in [*3] |-> ##2 !sdio_oe_out;
	endproperty
	a_abort: assert property (p_abort) else $error("abort ignored");
	property p_hw;
		disable iff (!rstn_in)
		hw_reset_in [*5] |=> active_regs_out == '0 && !sync_clk_out && !sdio_oe_out;
	endproperty
	a_hw: assert property (p_hw) else $error("pin reset ignored");
	property p_upd;
		!io_update_in [*8] |=> $stable(active_regs_out);
	endproperty
	a_upd: assert property (p_upd) else $error("active regs moved");
	property p_oer;
		$rose(sdio_oe_out) |-> !thr && !cs_n_in && !serial_port_abort_in;
	endproperty
	a_oer: assert property (p_oer) else $error("bad turnaround");
	c_rd2: cover property ($rose(sdio_oe_out));
	c_rd3: cover property ($rose(serial_out_pin_out));
	c_copy: cover property ($changed(active_regs_out));
endmodule : dsc_serial_port_chk
`default_nettype wire

// >>> dsc_host.sv
// Host serial master model at the far side of the port
`timescale 1ns/1ps
`default_nettype none
module dsc_host
(
	// Pacing clock
	input wire logic	mclk_in,
	// Serial pins
	output logic	cs_n_out,
	output logic	sclk_out,
	output logic	sdio_out,
	input wire logic	sdio_in,
	input wire logic	sdo_in
);
	// Idle: deselected, shift clock still
	initial
	begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdio_out = 1'b0;
	end
	// Step n core cycles, then 1 ns past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : tick
	// one frame of nb bits, 160 ns shift clock
	task automatic xfer(input logic sel, input logic [7:0] ins, input logic [31:0] wd,
		input logic lsb, input logic thr, input int nb, output logic [31:0] rd);
		int	i;
		int	j;
		logic	b;
		rd = 32'h0;
		cs_n_out = !sel;
		tick(8);
		for (i = 0; i < nb; i++)
		begin
			j = i - 8;
			b = (i < 8) ? ins[lsb ? i : 7 - i] : wd[lsb ? j : 31 - j];
			// Released line shows the inverse, never a stale bit
			sdio_out = (i >= 8 && ins[7]) ? !sdio_out : b;
			tick(8);
			sclk_out = 1'b1;
			if (i >= 8)
				rd[lsb ? j : 31 - j] = thr ? sdo_in : sdio_in;
			tick(8);
			sclk_out = 1'b0;
		end
	endtask : xfer
	// Deselect and release the data line
	task automatic desel();
		tick(8);
		cs_n_out = 1'b1;
		sdio_out = !sdio_out;
	endtask : desel
endmodule : dsc_host
`default_nettype wire

// >>> dsc_serial_port_tb_top.sv
// Self-checking bench of the serial control port
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.svh"
module dsc_serial_port_tb_top;
	// Pins and model state
	logic	mclk, rst_n, hw, abt, upd, cs_n, sclk, h_sd, sd, d_sd, d_oe, serial_out_pin, syn;
	logic [`DSC_NREG-1:0][`DSC_DW-1:0]	act;
	logic [31:0]	bm [4];
	logic [31:0]	am [4];
	logic [31:0]	r;
	int	fails, n_checks, t;
	// Data line level from both drivers
	assign sd = d_oe ? d_sd : h_sd;
	dsc_serial_port dut
	(
		.mclk_in(mclk), .rstn_in(rst_n), .hw_reset_in(hw),
		.serial_port_abort_in(abt), .cs_n_in(cs_n), .sclk_in(sclk),
		.sdio_in(sd), .io_update_in(upd), .sdio_out(d_sd), .sdio_oe_out(d_oe),
		.serial_out_pin_out(serial_out_pin), .sync_clk_out(syn), .active_regs_out(act)
	);
	dsc_host host
	(
		.mclk_in(mclk), .cs_n_out(cs_n), .sclk_out(sclk),
		.sdio_out(h_sd), .sdio_in(sd), .sdo_in(serial_out_pin)
	);
	// ========================================
	// Clock and checks
	initial
	begin
		mclk = 1'b0;
		forever
			#5 mclk = ~mclk;
	end
	task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %0t: word %h, expected %h", $time, g, e);
		end
	endtask : chk_w
	task automatic chk_act();
		int	i;
		for (i = 0; i < 4; i++)
			chk_w(act[i], am[i]);
	endtask : chk_act
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	// ========================================
	// Transfers; bit order and wire mode follow active reg 0
	task automatic frame(input logic s, input logic [7:0] ins, input logic [31:0] d, input int n);
		host.xfer(s, ins, d, am[0][`DSC_LSB_BIT], am[0][`DSC_3W_BIT], n, r);
	endtask : frame
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		frame(1'b1, {6'h00, a}, d, 40);
		bm[a] = d;
	endtask : wr
	task automatic rd(input logic [1:0] a);
		frame(1'b1, {6'h20, a}, 32'h0, 40);
		host.desel();
		chk_w(r, am[a]);
	endtask : rd
	// strobe held two sync periods each way
	task automatic update();
		int	k;
		// Raise the strobe just after a sync clock edge so it is settled at the next one
		for (k = 0; k < 8 && !syn; k++)
			host.tick(1);
		if (!syn)
		begin
			fails++;
			$display("ERROR %0t: sync clock stuck low", $time);
		end
		upd = 1'b1;
		host.tick(8);
		upd = 1'b0;
		host.tick(8);
		am = bm;
		chk_act();
	endtask : update
	// ========================================
	// Main sequence
	initial
	begin
		{rst_n, hw, abt, upd, fails, n_checks} = '0;
		void'($urandom(32'h0B34));
		for (t = 0; t < 4; t++)
			{bm[t], am[t]} = '0;
		host.tick(3);
		rst_n = 1'b1;
		host.tick(6);
		chk_act();
		$display("Test 1 done");
		// Back-to-back writes stay in the buffer until the strobe
		wr(2'h2, $urandom);
		wr(2'h1, $urandom);
		rd(2'h2);
		chk_act();
		update();
		rd(2'h2);
		$display("Test 2 done");
		// A frame while deselected is ignored
		frame(1'b0, 8'h02, ~bm[2], 40);
		host.desel();
		update();
		$display("Test 3 done");
		// abort mid-read, fresh read after release
		frame(1'b1, 8'h82, 32'h0, 20);
		abt = 1'b1;
		host.tick(3);
		abt = 1'b0;
		host.tick(4);
		rd(2'h2);
		$display("Test 4 done");
		// LSB first, 3-wire mode
		wr(2'h0, 32'h00000003);
		host.desel();
		update();
		wr(2'h3, $urandom);
		host.desel();
		update();
		rd(2'h3);
		rd(2'h0);
		$display("Test 5 done");
		// pin reset held six core cycles
		hw = 1'b1;
		host.tick(6);
		hw = 1'b0;
		host.tick(6);
		for (t = 0; t < 4; t++)
			{bm[t], am[t]} = '0;
		chk_act();
		rd(2'h2);
		$display("Test 6 done");
		tally_and_finish();
	end
	// Cut a hang short
	initial
	begin
		#900000;
		fails++;
		tally_and_finish();
	end
endmodule : dsc_serial_port_tb_top
bind dsc_serial_port dsc_serial_port_chk chk
(
	.mclk_in, .rstn_in, .hw_reset_in, .serial_port_abort_in, .cs_n_in, .sclk_in,
	.sdio_in, .io_update_in, .sdio_out, .sdio_oe_out, .serial_out_pin_out,
	.sync_clk_out, .active_regs_out
);
`default_nettype wire
